// File: hw/sweep_trig_defs.svh
// Purpose: Constants for the sweep trigger and gate controller
// Assumes: 100 MHz mclk_in, Avalon-MM byte addresses, one word per register
// Notes: Time registers count 125 ns ticks except holdoff, which counts 10 ns
`ifndef SWEEP_TRIG_DEFS_SVH
`define SWEEP_TRIG_DEFS_SVH
`define CLK_PERIOD_NS 10
`define TICK_NS 125
`define TICK_PAIR_CYC ((2 * `TICK_NS) / `CLK_PERIOD_NS)
`define TICK_SHORT_CYC (`TICK_PAIR_CYC / 2)
`define HOLD_STEP_NS 10
`define HOLD_MIN_NS 150
`define HOLD_MAX_S 10
`define HOLD_MIN_STEPS (`HOLD_MIN_NS / `HOLD_STEP_NS)
`define HOLD_MAX_STEPS (`HOLD_MAX_S * 64'd1000000000 / `HOLD_STEP_NS)
`define OFFS_MAX_S 13
`define OFFS_MAX_STEPS (`OFFS_MAX_S * 64'd1000000000 / `TICK_NS)
`define GATE_MIN_NS 125
`define GATE_MAX_S 100
`define GATE_MIN_STEPS (`GATE_MIN_NS / `TICK_NS)
`define GATE_MAX_STEPS (`GATE_MAX_S * 64'd1000000000 / `TICK_NS)
`define HYST_MIN_DB 3
`define HYST_MAX_DB 50
`define PRE_NUM 499
`define PRE_DIV 500
`define AV_AW 6
`define OFFS_W 28
`define TIME_W 30
`define LVL_W 8
`define HYST_W 6
`define OFF_CTRL 6'h00
`define OFF_OFFS 6'h04
`define OFF_HYST 6'h08
`define OFF_HOLD 6'h0C
`define OFF_GDLY 6'h10
`define OFF_GLEN 6'h14
`define OFF_SWT 6'h18
`define OFF_IFTH 6'h1C
`define OFF_STAT 6'h20
`define CTRL_SRC_LSB 0
`define CTRL_SRC_MSB 2
`define CTRL_NEG_BIT 3
`define CTRL_GATE_BIT 4
`define CTRL_EDGE_BIT 5
`define CTRL_ZSPAN_BIT 6
`define CTRL_RMSDET_BIT 7
`define CTRL_RUN_BIT 8
`define STAT_REFUSED_BIT 7
`define SWT_RST 30'h00001F40
`define IFTH_RST 8'h00
`endif

// File: hw/sweep_trig_pkg.sv
// Purpose: Types for the sweep trigger and gate controller
// Assumes: Constants come from sweep_trig_defs.svh
// Notes: Bus signals and the controls to the sweep engine travel as packed structs
`include "sweep_trig_defs.svh"
package sweep_trig_pkg;
  typedef enum logic [2:0] {
    SRC_FREE = 3'h0, SRC_EXT = 3'h1, SRC_VID = 3'h2, SRC_IFP = 3'h3, SRC_TIME = 3'h4
  } src_t;
  typedef enum logic [1:0] {S_IDLE = 2'h0, S_OFFS = 2'h1, S_SWEEP = 2'h2} sweep_st_t;
  typedef enum logic [1:0] {G_SHUT = 2'h0, G_WAIT = 2'h1, G_OPEN = 2'h2} gate_st_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [`AV_AW-1:0] address;
    logic [31:0] writedata;
  } av_req_t;
  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } av_rsp_t;
  typedef struct packed {
    logic start;
    logic run;
    logic trig_active;
    logic [`OFFS_W-1:0] pretrig;
  } sweep_ctl_t;
endpackage

// File: hw/sweep_trig_gate.sv
// Purpose: Decide when the sweep starts, pauses and resumes
// Assumes: Video and IF inputs come from logic on mclk_in; ext_trig_in is a pin
// Notes: Avalon-MM slave, one wait state on every access
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`include "sweep_trig_defs.svh"
module sweep_trig_gate (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input sweep_trig_pkg::av_req_t av_in,
  output sweep_trig_pkg::av_rsp_t av_out,
  input wire logic ext_trig_in,
  input wire logic video_trig_in,
  input wire logic [`LVL_W-1:0] if_level_in,
  input wire logic sweep_done_in,
  output sweep_trig_pkg::sweep_ctl_t sweep_out
);
  import sweep_trig_pkg::*;

  logic wait_q;
  logic [31:0] rdata_q;
  src_t src_q;
  logic neg_q;
  logic gate_q;
  logic edge_q;
  logic zspan_q;
  logic rmsdet_q;
  logic run_en_q;
  logic signed [`OFFS_W-1:0] offs_q;
  logic [`HYST_W-1:0] hyst_q;
  logic [`TIME_W-1:0] hold_q;
  logic [`TIME_W-1:0] gdly_q;
  logic [`TIME_W-1:0] glen_q;
  logic [`TIME_W-1:0] swt_q;
  logic [`LVL_W-1:0] ifth_q;
  logic refused_q;
  logic ext_m_q;
  logic ext_s_q;
  logic trg_prev_q;
  logic g_prev_q;
  logic if_armed_q;
  logic [3:0] tb_cnt_q;
  logic tb_ph_q;
  logic tb_restart;
  logic [`TIME_W-1:0] hold_cnt_q;
  logic [`OFFS_W-1:0] ofc_q;
  logic [`TIME_W-1:0] gcnt_q;
  sweep_st_t sst_q;
  sweep_st_t sst_d;
  gate_st_t gst_q;
  gate_st_t gst_d;
  logic start_q;
  logic run_q;
  logic trig_act_q;
  logic [`OFFS_W-1:0] pretrig_q;

  // Clamp a time setting into its legal range
  function automatic logic [`TIME_W-1:0] clamp_t(input logic [31:0] v,
                                                input logic [31:0] lo,
                                                input logic [31:0] hi);
    logic [31:0] r;
    r = (v < lo) ? lo : ((v > hi) ? hi : v);
    return r[`TIME_W-1:0];
  endfunction

  // Clamp a signed offset to plus or minus the largest offset
  function automatic logic [`OFFS_W-1:0] clamp_o(input logic signed [31:0] v);
    logic signed [31:0] m;
    logic signed [31:0] r;
    m = $signed(32'(`OFFS_MAX_STEPS));
    r = (v > m) ? m : ((v < -m) ? -m : v);
    return r[`OFFS_W-1:0];
  endfunction

  // Bus handshake and address decode
  wire req = av_in.read | av_in.write;
  wire we = av_in.write & ~wait_q;
  wire [`AV_AW-1:0] ad = av_in.address;
  wire [31:0] wd = av_in.writedata;
  wire ctrl_we = we && (ad == `OFF_CTRL);
  wire offs_we = we && (ad == `OFF_OFFS);
  wire hyst_we = we && (ad == `OFF_HYST);
  wire hold_we = we && (ad == `OFF_HOLD);
  wire gdly_we = we && (ad == `OFF_GDLY) && (src_q != SRC_TIME);
  wire glen_we = we && (ad == `OFF_GLEN) && (src_q != SRC_TIME);
  wire swt_we = we && (ad == `OFF_SWT);
  wire ifth_we = we && (ad == `OFF_IFTH);
  wire stat_we = we && (ad == `OFF_STAT);

  // Source decode on a control write, with forced switch to IF power
  wire [2:0] w_src_raw = wd[`CTRL_SRC_MSB:`CTRL_SRC_LSB];
  wire w_gate = wd[`CTRL_GATE_BIT];
  wire w_zsp = wd[`CTRL_ZSPAN_BIT];
  src_t w_src;
  src_t src_new;
  assign w_src = (w_src_raw > SRC_TIME) ? SRC_FREE : src_t'(w_src_raw);
  wire w_fit = (w_src == SRC_EXT) || (w_src == SRC_IFP) || (w_zsp && (w_src == SRC_VID));
  assign src_new = (w_gate && !w_fit) ? SRC_IFP : w_src;

  // Offset write checks and gate-delay coupling
  wire signed [31:0] w_offs = 32'(signed'(wd[`OFFS_W-1:0]));
  wire neg_ok = zspan_q & ~gate_q & ~rmsdet_q;
  wire offs_ref = offs_we & w_offs[31] & ~neg_ok;
  wire [`TIME_W-1:0] gd_new = clamp_t(wd, 32'(`GATE_MIN_STEPS), 32'(`GATE_MAX_STEPS));
  wire couple = (src_q == SRC_EXT) || (src_q == SRC_IFP);
  wire signed [31:0] offs_shift = 32'(offs_q) + $signed({2'b00, gd_new})
                                  - $signed({2'b00, gdly_q});

  // Effective offset and pre-trigger limit
  wire signed [`OFFS_W-1:0] offs_eff = (offs_q[`OFFS_W-1] && !neg_ok) ? '0 : offs_q;
  wire offs_pos = !offs_eff[`OFFS_W-1] && (offs_eff != '0);
  wire [`OFFS_W-1:0] mag = offs_eff[`OFFS_W-1] ? `OFFS_W'(-offs_eff) : '0;
  wire [39:0] pre_lim = (40'(swt_q) * 40'(`PRE_NUM)) / 40'(`PRE_DIV);
  wire [`TIME_W-1:0] pre_res = swt_q / `TIME_W'(`PRE_DIV);
  wire [`OFFS_W-1:0] magc = (40'(mag) > pre_lim) ? pre_lim[`OFFS_W-1:0] : mag;
  wire [`OFFS_W-1:0] magq = (pre_res == '0) ? magc
                            : `OFFS_W'(magc - `OFFS_W'(`TIME_W'(magc) % pre_res));

  // Read-back multiplexer
  wire [31:0] ctrl_rd = {23'h000000, run_en_q, rmsdet_q, zspan_q, edge_q, gate_q, neg_q, src_q};
  wire [31:0] stat_rd = {24'h000000, hold_cnt_q != '0, refused_q, if_armed_q, gst_q, sst_q,
                         trig_act_q};
  wire [31:0] rd_mux =
    (ad == `OFF_CTRL) ? ctrl_rd :
    (ad == `OFF_OFFS) ? 32'(signed'(offs_q)) :
    (ad == `OFF_HYST) ? 32'(hyst_q) :
    (ad == `OFF_HOLD) ? 32'(hold_q) :
    (ad == `OFF_GDLY) ? 32'(gdly_q) :
    (ad == `OFF_GLEN) ? 32'(glen_q) :
    (ad == `OFF_SWT) ? 32'(swt_q) :
    (ad == `OFF_IFTH) ? 32'(ifth_q) :
    (ad == `OFF_STAT) ? stat_rd : 32'h00000000;

  // One wait state, then the answer for one cycle
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      wait_q <= wait_q ? ~req : 1'b1;
      if (wait_q && av_in.read)
        rdata_q <= rd_mux;
    end
  end

  // Control register
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      src_q <= SRC_FREE;
      neg_q <= 1'b0;
      gate_q <= 1'b0;
      edge_q <= 1'b0;
      zspan_q <= 1'b0;
      rmsdet_q <= 1'b0;
      run_en_q <= 1'b0;
    end
    else if (ctrl_we)
    begin
      src_q <= src_new;
      neg_q <= wd[`CTRL_NEG_BIT];
      gate_q <= w_gate;
      edge_q <= wd[`CTRL_EDGE_BIT];
      zspan_q <= w_zsp;
      rmsdet_q <= wd[`CTRL_RMSDET_BIT];
      run_en_q <= wd[`CTRL_RUN_BIT];
    end
  end

  // Trigger offset, refused-write flag with set over clear
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      offs_q <= '0;
      refused_q <= 1'b0;
    end
    else
    begin
      if (offs_we && !offs_ref)
        offs_q <= clamp_o(w_offs);
      else if (gdly_we && couple)
        offs_q <= clamp_o(offs_shift);
      refused_q <= offs_ref | (refused_q & ~(stat_we & wd[`STAT_REFUSED_BIT]));
    end
  end

  // Time and level settings; hyst, holdoff and gate times clamped to their ranges, swt and ifth taken as written
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      hyst_q <= `HYST_W'(`HYST_MIN_DB);
      hold_q <= `TIME_W'(`HOLD_MIN_STEPS);
      gdly_q <= `TIME_W'(`GATE_MIN_STEPS);
      glen_q <= `TIME_W'(`GATE_MIN_STEPS);
      swt_q <= `SWT_RST;
      ifth_q <= `IFTH_RST;
    end
    else
    begin
      if (hyst_we)
        hyst_q <= `HYST_W'(clamp_t(wd, 32'(`HYST_MIN_DB), 32'(`HYST_MAX_DB)));
      if (hold_we)
        hold_q <= clamp_t(wd, 32'(`HOLD_MIN_STEPS), 32'(`HOLD_MAX_STEPS));
      if (gdly_we)
        gdly_q <= gd_new;
      if (glen_we)
        glen_q <= gd_new;
      if (swt_we)
        swt_q <= wd[`TIME_W-1:0];
      if (ifth_we)
        ifth_q <= wd[`LVL_W-1:0];
    end
  end

  // 125 ns time base: alternating 12 and 13 cycle periods, restarted when a count loads
  // so that a delay or length of N ticks lasts N whole ticks, not up to one tick less
  wire [3:0] tb_lim = tb_ph_q ? 4'(`TICK_PAIR_CYC - `TICK_SHORT_CYC - 1)
                              : 4'(`TICK_SHORT_CYC - 1);
  wire tick = (tb_cnt_q == tb_lim);

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      tb_cnt_q <= 4'h0;
      tb_ph_q <= 1'b0;
    end
    else if (tb_restart)
    begin
      tb_cnt_q <= 4'h0;
      tb_ph_q <= 1'b0;
    end
    else if (tick)
    begin
      tb_cnt_q <= 4'h0;
      tb_ph_q <= ~tb_ph_q;
    end
    else
      tb_cnt_q <= tb_cnt_q + 4'h1;
  end

  // Pin synchroniser; only the second stage feeds logic
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ext_m_q <= 1'b0;
      ext_s_q <= 1'b0;
    end
    else
    begin
      ext_m_q <= ext_trig_in;
      ext_s_q <= ext_m_q;
    end
  end

  // Trigger events per source
  wire trg_raw = (src_q == SRC_EXT) ? ext_s_q : video_trig_in;
  wire trg_edge = neg_q ? (~trg_raw & trg_prev_q) : (trg_raw & ~trg_prev_q);
  wire if_over = (if_level_in >= ifth_q);
  wire [`LVL_W:0] if_lo = {1'b0, ifth_q} - (`LVL_W+1)'(hyst_q);
  wire if_below = !if_lo[`LVL_W] && (if_level_in < if_lo[`LVL_W-1:0]);
  wire hold_busy = (hold_cnt_q != '0);
  wire src_ev = ((src_q == SRC_EXT) || (src_q == SRC_VID)) ? trg_edge :
                (src_q == SRC_IFP) ? (if_armed_q & if_over) : (src_q == SRC_TIME);
  wire trig_acc = src_ev & ~hold_busy
                  & ((sst_q == S_IDLE) | (src_q == SRC_TIME));

  // Hysteresis arming and holdoff counter
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      trg_prev_q <= 1'b0;
      if_armed_q <= 1'b1;
      hold_cnt_q <= '0;
    end
    else
    begin
      trg_prev_q <= trg_raw;
      if (if_below)
        if_armed_q <= 1'b1;
      else if (trig_acc && (src_q == SRC_IFP))
        if_armed_q <= 1'b0;
      if (trig_acc)
        hold_cnt_q <= hold_q;
      else if (hold_busy)
        hold_cnt_q <= hold_cnt_q - `TIME_W'(1);
    end
  end

  // Gate source, polarity and availability
  wire gate_eff = gate_q & (src_q != SRC_TIME);
  wire g_raw = (src_q == SRC_EXT) ? ext_s_q :
               (src_q == SRC_IFP) ? if_over : video_trig_in;
  wire g_lvl = g_raw ^ neg_q;
  wire g_rise = g_lvl & ~g_prev_q;

  // Sweep sequencing
  wire idle_go = (sst_q == S_IDLE) & run_en_q;
  wire go_offs = idle_go & ~gate_eff & trig_acc & offs_pos;
  wire go_now = idle_go & ((src_q == SRC_FREE) | gate_eff | (trig_acc & ~offs_pos));

  always_comb
  begin
    sst_d = sst_q;
    unique case (sst_q)
      S_IDLE:
        if (go_now)
          sst_d = S_SWEEP;
        else if (go_offs)
          sst_d = S_OFFS;
      S_OFFS:
        if (!run_en_q)
          sst_d = S_IDLE;
        else if (ofc_q == '0)
          sst_d = S_SWEEP;
      S_SWEEP:
        if (sweep_done_in || !run_en_q)
          sst_d = S_IDLE;
      default:
        sst_d = S_IDLE;
    endcase
  end

  // Gate sequencing
  always_comb
  begin
    gst_d = gst_q;
    unique case (gst_q)
      G_SHUT:
        if (edge_q ? g_rise : g_lvl)
          gst_d = G_WAIT;
      G_WAIT:
        if (!edge_q && !g_lvl)
          gst_d = G_SHUT;
        else if (gcnt_q == '0)
          gst_d = G_OPEN;
      G_OPEN:
        if (edge_q ? (gcnt_q == '0) : !g_lvl)
          gst_d = G_SHUT;
      default:
        gst_d = G_SHUT;
    endcase
    if (!gate_eff)
      gst_d = G_SHUT;
  end

  // A delay, length or offset count loads here; the time base restarts with it
  wire gate_load = ((gst_q == G_SHUT) && (gst_d == G_WAIT))
                   || ((gst_q == G_WAIT) && (gst_d == G_OPEN));
  assign tb_restart = go_offs | gate_load;

  // State registers and the delay counters
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sst_q <= S_IDLE;
      gst_q <= G_SHUT;
      g_prev_q <= 1'b0;
      ofc_q <= '0;
      gcnt_q <= '0;
    end
    else
    begin
      sst_q <= sst_d;
      gst_q <= gst_d;
      g_prev_q <= g_lvl;
      if (go_offs)
        ofc_q <= offs_eff;
      else if ((sst_q == S_OFFS) && tick && (ofc_q != '0))
        ofc_q <= ofc_q - `OFFS_W'(1);
      if ((gst_q == G_SHUT) && (gst_d == G_WAIT))
        gcnt_q <= gdly_q;
      else if ((gst_q == G_WAIT) && (gst_d == G_OPEN))
        gcnt_q <= glen_q;
      else if (tick && (gcnt_q != '0))
        gcnt_q <= gcnt_q - `TIME_W'(1);
    end
  end

  // Registered outputs to the sweep engine
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      start_q <= 1'b0;
      run_q <= 1'b0;
      trig_act_q <= 1'b0;
      pretrig_q <= '0;
    end
    else
    begin
      start_q <= (sst_d == S_SWEEP) && (sst_q != S_SWEEP);
      run_q <= (sst_d == S_SWEEP) && (!gate_eff || (gst_d == G_OPEN));
      trig_act_q <= (src_q != SRC_FREE);
      if ((sst_d == S_SWEEP) && (sst_q == S_IDLE))
        pretrig_q <= magq;
      else if (sst_d != S_SWEEP)
        pretrig_q <= '0;
    end
  end

  assign av_out.waitrequest = wait_q;
  assign av_out.readdata = rdata_q;
  assign sweep_out.start = start_q;
  assign sweep_out.run = run_q;
  assign sweep_out.trig_active = trig_act_q;
  assign sweep_out.pretrig = pretrig_q;

  // Checks on the sequencing
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);

  AST_TRG_ACTIVE: assert property ((ctrl_we && src_new == SRC_FREE) ##1 !ctrl_we
                                   |=> !trig_act_q)
    else $error("trigger active while free run");
  AST_FREE_RESTART: assert property ((sst_q == S_SWEEP && sweep_done_in && src_q == SRC_FREE
                                      && run_en_q && !ctrl_we) ##1 !ctrl_we |=> start_q)
    else $error("free run did not restart");
  AST_HOLDOFF: assert property (trig_acc |=> !trig_acc [*8])
    else $error("trigger accepted inside holdoff");
  AST_POS_OFFSET: assert property ((sst_q == S_IDLE ##1 sst_q == S_OFFS) |-> !start_q [*8])
    else $error("positive offset did not delay start");
  AST_NEG_REFUSED: assert property (offs_ref |=> (refused_q && $stable(offs_q)))
    else $error("negative offset not refused");
  AST_PRETRIG: assert property ((start_q && $stable(swt_q))
                                |-> (40'(pretrig_q) <= pre_lim))
    else $error("pre-trigger beyond limit");
  AST_LEVEL_SHUT: assert property ((gate_eff && !edge_q && !g_lvl && !ctrl_we)
                                   |=> !run_q)
    else $error("sweep runs with level gate low");
  AST_EDGE_LEN: assert property ((edge_q && gst_q == G_OPEN && gcnt_q == '0 && !ctrl_we)
                                 |=> gst_q == G_SHUT)
    else $error("edge gate open past its length");
  AST_DELAY_DONE: assert property ($rose(gst_q == G_OPEN)
                                   |-> ($past(gst_q) == G_WAIT && $past(gcnt_q) == '0))
    else $error("gate opened before delay expired");
  AST_GATE_SRC: assert property (gate_q |-> (src_q == SRC_EXT || src_q == SRC_IFP
                                             || (zspan_q && src_q == SRC_VID)))
    else $error("gate enabled with unfit source");

  COV_OFFS_START: cover property (sst_q == S_OFFS ##1 sst_q == S_SWEEP);
  COV_EDGE_GATE: cover property (edge_q && gst_q == G_WAIT ##1 gst_q == G_OPEN);
  COV_FORCED_IFP: cover property (ctrl_we && w_gate && !w_fit);
  COV_TIME_TRIG: cover property (src_q == SRC_TIME && trig_acc && sst_q == S_IDLE);
endmodule

// File: dv/sweep_engine_model.sv
// Purpose: Sweep engine and trigger pin model facing the controller
// Assumes: The sweep advances only while run is high
// Notes: The pin level is retimed so it holds for whole clock cycles
module sweep_engine_model #(
  parameter int SWEEP_CYC = 200
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input sweep_trig_pkg::sweep_ctl_t ctl_in,
  input wire logic pin_lvl_in,
  output logic done_out,
  output logic ext_trig_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import sweep_trig_pkg::*;
  int unsigned cnt_q;
  // Count run cycles of the sweep and flag its end
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cnt_q <= 0;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      if (ctl_in.start)
        cnt_q <= SWEEP_CYC;
      else if (ctl_in.run && cnt_q == 1)
      begin
        cnt_q <= 0;
        done_out <= 1'b1;
      end
      else if (ctl_in.run && cnt_q > 1)
        cnt_q <= cnt_q - 1;
    end
  end
  // Pin changes only at an edge, so it never glitches within a cycle
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      ext_trig_out <= 1'b0;
    else
      ext_trig_out <= pin_lvl_in;
  end
endmodule

// File: dv/sweep_trig_gate_tb_top.sv
// Purpose: Self-checking bench for the sweep trigger and gate controller
// Assumes: Sweep engine model ends each sweep after SWEEP_CYC run cycles
// Notes: Registers reached over Avalon-MM; sweep timing checked in windows
`include "sweep_trig_defs.svh"
module sweep_trig_gate_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sweep_trig_pkg::*;
  localparam int SWEEP_CYC = 200;
  logic mclk_in, rst_b_in, pin_lvl, ext_pin, video_trig, sweep_done;
  logic [`LVL_W-1:0] if_level;
  av_req_t av_req;
  av_rsp_t av_rsp;
  sweep_ctl_t sweep_ctl;
  int num_errors, comparisons, n;
  logic [31:0] q;
  logic [31:0] rst_exp [10] = '{32'h0, 32'h0, 32'h3, 32'hF, 32'h1, 32'h1, 32'h1F40, 32'h0,
    32'h20, 32'h0};

  sweep_trig_gate dut_u (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .av_in(av_req),
    .av_out(av_rsp), .ext_trig_in(ext_pin), .video_trig_in(video_trig),
    .if_level_in(if_level), .sweep_done_in(sweep_done), .sweep_out(sweep_ctl));
  sweep_engine_model #(.SWEEP_CYC(SWEEP_CYC)) eng_u (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .ctl_in(sweep_ctl), .pin_lvl_in(pin_lvl), .done_out(sweep_done), .ext_trig_out(ext_pin));

  // Clock at 100 MHz
  initial
  begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic stop_test;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("FAIL t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic chkr(input int g, input int lo, input int hi, input string m);
    comparisons++;
    if (g < lo || g > hi)
    begin
      num_errors++;
      $display("FAIL t=%0t %s took %0d cycles", $time, m, g);
    end
  endtask

  // One bus access held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    av_req <= '{read: !w, write: w, address: a, writedata: d};
    do
    begin
      @(posedge mclk_in);
      k++;
    end
    while (av_rsp.waitrequest !== 1'b0 && k < 50);
    q = av_rsp.readdata;
    if (k >= 50)
      chk(32'h0, 32'h1, "bus hang");
    av_req <= '{read: 1'b0, write: 1'b0, address: a, writedata: d};
    @(posedge mclk_in);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 32'h0);
    chk(q, e, m);
  endtask

  // Count edges until start or run shows the wanted level
  task automatic wsig(input bit use_run, input logic v, input int lim);
    n = 0;
    while ((use_run ? sweep_ctl.run : sweep_ctl.start) !== v && n < lim)
    begin
      @(posedge mclk_in);
      n++;
    end
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge mclk_in);
  endtask

  // Watchdog well beyond the expected run length
  initial
  begin
    idle(10000);
    num_errors++;
    $display("FAIL t=%0t watchdog expired", $time);
    stop_test();
  end

  // Test sequence
  initial
  begin
    rst_b_in = 1'b0;
    pin_lvl = 1'b0;
    video_trig = 1'b0;
    if_level = 8'h00;
    av_req = '0;
    num_errors = 0;
    comparisons = 0;
    idle(10);
    rst_b_in <= 1'b1;
    @(posedge mclk_in);
    for (int i = 0; i < 10; i++) rd(6'(i * 4), rst_exp[i], "reset value");
    chk(sweep_ctl.trig_active, 1'b0, "flag after reset");
    $display("test reset done");
    wr(`OFF_HYST, 32'h1);
    rd(`OFF_HYST, 32'h3, "hyst low");
    wr(`OFF_HYST, 32'h3C);
    rd(`OFF_HYST, 32'h32, "hyst high");
    wr(`OFF_HOLD, 32'h1);
    rd(`OFF_HOLD, 32'hF, "hold low");
    wr(`OFF_OFFS, 32'h7FFFFFF);
    rd(`OFF_OFFS, 32'h632EA00, "offset clamp");
    wr(`OFF_OFFS, 32'h0);
    wr(`OFF_OFFS, 32'hFFFFFFFD);
    rd(`OFF_OFFS, 32'h0, "neg with span");
    rd(`OFF_STAT, 32'h60, "refused set");
    wr(`OFF_STAT, 32'h80);
    rd(`OFF_STAT, 32'h20, "refused clear");
    wr(`OFF_CTRL, 32'hC0);
    wr(`OFF_OFFS, 32'hFFFFFFFD);
    rd(`OFF_OFFS, 32'h0, "neg with rms");
    wr(`OFF_CTRL, 32'h40);
    wr(`OFF_OFFS, 32'hFFFFFFFD);
    rd(`OFF_OFFS, 32'hFFFFFFFD, "neg zero span");
    wr(`OFF_OFFS, 32'h0);
    $display("test settings done");
    wr(`OFF_CTRL, 32'h12);
    rd(`OFF_CTRL, 32'h13, "video gate span");
    wr(`OFF_CTRL, 32'h14);
    rd(`OFF_CTRL, 32'h13, "timer gate");
    wr(`OFF_CTRL, 32'h52);
    rd(`OFF_CTRL, 32'h52, "video gate zero span");
    wr(`OFF_CTRL, 32'h1);
    wr(`OFF_GDLY, 32'h4);
    rd(`OFF_OFFS, 32'h3, "delay moves offset");
    wr(`OFF_CTRL, 32'h4);
    wr(`OFF_GDLY, 32'h7);
    rd(`OFF_GDLY, 32'h4, "timer locks delay");
    for (int s = 1; s < 5; s++)
    begin
      wr(`OFF_CTRL, 32'(s));
      chk(sweep_ctl.trig_active, 1'b1, "flag per source");
    end
    wr(`OFF_CTRL, 32'h0);
    wr(`OFF_OFFS, 32'h0);
    wr(`OFF_GDLY, 32'h2);
    wr(`OFF_GLEN, 32'h4);
    $display("test source done");
    wr(`OFF_CTRL, 32'h101);
    pin_lvl <= 1'b1;
    wsig(1'b0, 1'b1, 20);
    chkr(n, 1, 19, "rising start");
    idle(260);
    wr(`OFF_CTRL, 32'h109);
    pin_lvl <= 1'b0;
    wsig(1'b0, 1'b1, 20);
    chkr(n, 1, 19, "falling start");
    idle(260);
    pin_lvl <= 1'b1;
    wsig(1'b0, 1'b1, 30);
    chkr(n, 30, 30, "no start on rise");
    $display("test polarity done");
    wr(`OFF_CTRL, 32'h0);
    idle(260);
    wr(`OFF_HOLD, 32'h12C);
    wr(`OFF_CTRL, 32'h104);
    wsig(1'b0, 1'b1, 400);
    @(posedge mclk_in);
    wsig(1'b0, 1'b1, 400);
    chkr(n, 294, 306, "timer period");
    wr(`OFF_CTRL, 32'h100);
    wsig(1'b0, 1'b1, 400);
    @(posedge mclk_in);
    wsig(1'b0, 1'b1, 400);
    chkr(n, SWEEP_CYC, SWEEP_CYC + 8, "free run restart");
    chk(sweep_ctl.trig_active, 1'b0, "free run flag");
    wr(`OFF_CTRL, 32'h0);
    pin_lvl <= 1'b0;
    idle(260);
    $display("test timing done");
    wr(`OFF_CTRL, 32'h111);
    idle(20);
    chk(sweep_ctl.run, 1'b0, "gate low halts");
    pin_lvl <= 1'b1;
    wsig(1'b1, 1'b1, 60);
    chkr(n, 24, 34, "level gate delay");
    pin_lvl <= 1'b0;
    wsig(1'b1, 1'b0, 20);
    chkr(n, 1, 6, "level gate shut");
    wr(`OFF_CTRL, 32'h131);
    idle(10);
    pin_lvl <= 1'b1;
    wsig(1'b1, 1'b1, 60);
    chkr(n, 24, 34, "edge gate delay");
    wsig(1'b1, 1'b0, 100);
    chkr(n, 48, 52, "edge gate length");
    $display("test gate done");
    pin_lvl <= 1'b0;
    wr(`OFF_CTRL, 32'h40);
    wr(`OFF_OFFS, 32'h2);
    wr(`OFF_CTRL, 32'h141);
    pin_lvl <= 1'b1;
    wsig(1'b0, 1'b1, 40);
    chkr(n, 28, 33, "offset delays start");
    idle(320);
    pin_lvl <= 1'b0;
    wr(`OFF_OFFS, 32'hFFFFFFD8);
    pin_lvl <= 1'b1;
    wsig(1'b0, 1'b1, 20);
    chkr(n, 1, 19, "pre-trigger start");
    chk(sweep_ctl.pretrig, 32'(40 - 40 % (`SWT_RST / `PRE_DIV)), "pretrig amount");
    idle(320);
    $display("test offset done");
    wr(`OFF_IFTH, 32'h40);
    wr(`OFF_CTRL, 32'h103);
    if_level <= 8'h50;
    wsig(1'b0, 1'b1, 20);
    chkr(n, 1, 19, "IF trigger");
    if_level <= 8'h20;
    idle(320);
    if_level <= 8'h50;
    wsig(1'b0, 1'b1, 30);
    chkr(n, 30, 30, "IF stays disarmed");
    if_level <= 8'h0A;
    idle(2);
    if_level <= 8'h50;
    wsig(1'b0, 1'b1, 20);
    chkr(n, 1, 19, "IF re-armed");
    idle(320);
    wr(`OFF_CTRL, 32'h102);
    video_trig <= 1'b1;
    wsig(1'b0, 1'b1, 20);
    chkr(n, 1, 19, "video trigger");
    $display("test sources done");
    stop_test();
  end
endmodule
